// ### src/kr_pcs_status_seed_pkg.sv
// constants, field layouts and carrier types of the coding-sublayer status and seed register bank
// assumes a clause 45 management station on mdc/mdio and live status from the sublayer datapath
//
// Notes on behaviour
// - answer only device 0x03 and 0x1e accesses in kr mode
// - second sublayer status at 0x0008, reset 0x8001
// - bits 15:14 of it always read 2'b10
// - bit 11 latches transmit fault until read
// - bit 10 latches receive fault until read
// - bit 0 always reads 1, coding capability
// - first kr status at 0x0020, reset 0x0004
// - bit 12 shows live receive link state
// - bit 2 always reads 1, prbs31 capability
// - bit 1 shows live high error rate
// - bit 0 shows live block lock
// - second kr status at 0x0021, reset 0x0000
// - bit 15 latched-low block lock until read
// - bit 14 latched high error rate until read
// - bits 13:8 bad header count, clear on read
// - bits 7:0 errored block count, clear on read
// - errored count also at 1E.0010, shared clear
// - seed word 0x0022 holds bits 15:0
// - seed word 0x0023 holds bits 31:16
package kr_pcs_status_seed_pkg;

    // management frame layout
    localparam logic [5:0] PREAMBLE_LEN = 6'h20;
    localparam logic [5:0] HEADER_LAST = 6'h0b;
    localparam logic [5:0] DATA_LAST = 6'h0f;
    localparam logic [5:0] READ_EDGES = 6'h10;
    localparam logic [1:0] OP_ADDRESS = 2'h0;
    localparam logic [1:0] OP_WRITE = 2'h1;
    localparam logic [1:0] OP_READ_INC = 2'h2;

    // device addresses
    localparam logic [4:0] DEV_PCS = 5'h03;
    localparam logic [4:0] DEV_VENDOR = 5'h1e;

    // register offsets
    localparam logic [15:0] SUBLAYER_STATUS_TWO_ADDR = 16'h0008;
    localparam logic [15:0] KR_STATUS_ONE_ADDR = 16'h0020;
    localparam logic [15:0] KR_STATUS_TWO_ADDR = 16'h0021;
    localparam logic [15:0] SEED_A_WORD0_ADDR = 16'h0022;
    localparam logic [15:0] SEED_A_WORD1_ADDR = 16'h0023;
    localparam logic [15:0] VENDOR_ERR_COUNT_ADDR = 16'h0010;

    // reset values
    localparam logic [15:0] SUBLAYER_STATUS_TWO_RESET = 16'h8001;
    localparam logic [15:0] KR_STATUS_ONE_RESET = 16'h0004;
    localparam logic [15:0] KR_STATUS_TWO_RESET = 16'h0000;
    localparam logic [15:0] SEED_RESET = 16'h0000;

    // fixed field values
    localparam logic [1:0] UNIT_PRESENCE_CODE = 2'h2;
    localparam logic KR_CODING_CAPABILITY = 1'b1;
    localparam logic LONG_PRBS_CAPABILITY = 1'b1;
    localparam logic [5:0] BAD_HEADER_COUNT_MAX = 6'h3f;
    localparam logic [7:0] ERRORED_BLOCK_COUNT_MAX = 8'hff;

    // field positions inside the status words
    localparam logic [3:0] PRESENCE_POS = 4'he;
    localparam logic [3:0] TX_FAULT_POS = 4'hb;
    localparam logic [3:0] RX_FAULT_POS = 4'ha;
    localparam logic [3:0] CODING_CAP_POS = 4'h0;
    localparam logic [3:0] LINK_UP_POS = 4'hc;
    localparam logic [3:0] PRBS_CAP_POS = 4'h2;
    localparam logic [3:0] HIGH_ERROR_POS = 4'h1;
    localparam logic [3:0] LOCK_POS = 4'h0;
    localparam logic [3:0] LOCK_LL_POS = 4'hf;
    localparam logic [3:0] HIGH_ERROR_LH_POS = 4'he;
    localparam logic [3:0] BAD_HEADER_POS = 4'h8;
    localparam logic [3:0] ERRORED_POS = 4'h0;

    typedef enum logic [2:0] {
        FR_PREAMBLE,
        FR_START,
        FR_HEADER,
        FR_TURN,
        FR_READ,
        FR_WRITE
    } frame_state_type;

    // live status from the datapath; the entry strobes are one-cycle pulses
    typedef struct packed {
        logic receive_link_up;
        logic high_error_rate_live;
        logic block_lock_live;
        logic transmit_fault;
        logic receive_fault;
        logic bad_sync_header_entry;
        logic decode_error_entry;
    } pcs_status_type;

    typedef struct packed {
        frame_state_type st;
        logic mdc_d;
        logic [5:0] cnt;
        logic [11:0] hdr;
        logic [15:0] shift;
        logic [1:0] op;
        logic sel_pcs;
        logic sel_vendor;
        logic [15:0] addr_pcs;
        logic [15:0] addr_vendor;
        logic mdio_oe;
        logic mdio_o;
        logic transmit_fault_latch;
        logic receive_fault_latch;
        logic block_lock_latched_low;
        logic high_error_rate_latched;
        logic [5:0] bad_header_entry_count;
        logic [7:0] errored_block_count;
        logic [15:0] pattern_seed_word0;
        logic [15:0] pattern_seed_word1;
    } bank_state_type;

    localparam bank_state_type BANK_RESET = '0;

endpackage

// ### src/kr_pcs_status_seed_regs.sv
// clause 45 management slave holding the kr coding-sublayer status registers and the seed a low and high words
// assumes mdc and mdio are already synchronous to core_clk_in and mdc is far slower than it
`timescale 1ns/1ps
module kr_pcs_status_seed_regs (
    input wire logic core_clk_in,
    input wire logic sys_rst_in,
    input wire logic kr_mode_in,
    input wire logic [4:0] port_addr_in,
    input wire logic mdc_in,
    input wire logic mdio_in,
    output logic mdio_out,
    output logic mdio_oe_out,
    input wire kr_pcs_status_seed_pkg::pcs_status_type pcs_status_in,
    output logic [31:0] pattern_seed_first_out
);

    kr_pcs_status_seed_pkg::bank_state_type r;
    kr_pcs_status_seed_pkg::bank_state_type n;

    // saturating increment shared by both event counters
    function automatic logic [7:0] sat_inc(input logic [7:0] v, input logic [7:0] max);
        sat_inc = (v == max) ? v : v + 8'h01;
    endfunction

    // read word of device 0x03; unmapped offsets read as zero
    function automatic logic [15:0] pcs_word(input logic [15:0] a,
                                             input kr_pcs_status_seed_pkg::bank_state_type s,
                                             input kr_pcs_status_seed_pkg::pcs_status_type p);
        pcs_word = 16'h0000;
        if (a == kr_pcs_status_seed_pkg::SUBLAYER_STATUS_TWO_ADDR) begin
            pcs_word[kr_pcs_status_seed_pkg::PRESENCE_POS +: 2] = kr_pcs_status_seed_pkg::UNIT_PRESENCE_CODE;
            pcs_word[kr_pcs_status_seed_pkg::TX_FAULT_POS] = s.transmit_fault_latch;
            pcs_word[kr_pcs_status_seed_pkg::RX_FAULT_POS] = s.receive_fault_latch;
            pcs_word[kr_pcs_status_seed_pkg::CODING_CAP_POS] = kr_pcs_status_seed_pkg::KR_CODING_CAPABILITY;
        end else if (a == kr_pcs_status_seed_pkg::KR_STATUS_ONE_ADDR) begin
            pcs_word[kr_pcs_status_seed_pkg::LINK_UP_POS] = p.receive_link_up;
            pcs_word[kr_pcs_status_seed_pkg::PRBS_CAP_POS] = kr_pcs_status_seed_pkg::LONG_PRBS_CAPABILITY;
            pcs_word[kr_pcs_status_seed_pkg::HIGH_ERROR_POS] = p.high_error_rate_live;
            pcs_word[kr_pcs_status_seed_pkg::LOCK_POS] = p.block_lock_live;
        end else if (a == kr_pcs_status_seed_pkg::KR_STATUS_TWO_ADDR) begin
            pcs_word[kr_pcs_status_seed_pkg::LOCK_LL_POS] = s.block_lock_latched_low;
            pcs_word[kr_pcs_status_seed_pkg::HIGH_ERROR_LH_POS] = s.high_error_rate_latched;
            pcs_word[kr_pcs_status_seed_pkg::BAD_HEADER_POS +: 6] = s.bad_header_entry_count;
            pcs_word[kr_pcs_status_seed_pkg::ERRORED_POS +: 8] = s.errored_block_count;
        end else if (a == kr_pcs_status_seed_pkg::SEED_A_WORD0_ADDR) begin
            pcs_word = s.pattern_seed_word0;
        end else if (a == kr_pcs_status_seed_pkg::SEED_A_WORD1_ADDR) begin
            pcs_word = s.pattern_seed_word1;
        end
    endfunction

    always_comb begin
        logic rise;
        logic [11:0] h;
        logic [15:0] w;
        logic clr_sub2;
        logic clr_kr2;
        logic clr_err;
        rise = 1'b0;
        h = 12'h000;
        w = 16'h0000;
        clr_sub2 = 1'b0;
        clr_kr2 = 1'b0;
        clr_err = 1'b0;
        n = r;
        n.mdc_d = mdc_in;
        rise = mdc_in & ~r.mdc_d;
        if (rise) begin
            unique case (r.st)
                kr_pcs_status_seed_pkg::FR_PREAMBLE: begin
                    if (mdio_in) begin
                        if (r.cnt != kr_pcs_status_seed_pkg::PREAMBLE_LEN) begin
                            n.cnt = r.cnt + 6'h01;
                        end
                    end else begin
                        if (r.cnt == kr_pcs_status_seed_pkg::PREAMBLE_LEN) begin
                            n.st = kr_pcs_status_seed_pkg::FR_START;
                        end
                        n.cnt = 6'h00;
                    end
                end
                kr_pcs_status_seed_pkg::FR_START: begin
                    // clause 45 start is two zeros; a one here is taken as fresh preamble
                    if (!mdio_in) begin
                        n.st = kr_pcs_status_seed_pkg::FR_HEADER;
                        n.cnt = 6'h00;
                    end else begin
                        n.st = kr_pcs_status_seed_pkg::FR_PREAMBLE;
                        n.cnt = 6'h01;
                    end
                end
                kr_pcs_status_seed_pkg::FR_HEADER: begin
                    h = {r.hdr[10:0], mdio_in};
                    n.hdr = h;
                    n.cnt = r.cnt + 6'h01;
                    if (r.cnt == kr_pcs_status_seed_pkg::HEADER_LAST) begin
                        n.op = h[11:10];
                        n.sel_pcs = kr_mode_in && (h[9:5] == port_addr_in)
                            && (h[4:0] == kr_pcs_status_seed_pkg::DEV_PCS);
                        n.sel_vendor = kr_mode_in && (h[9:5] == port_addr_in)
                            && (h[4:0] == kr_pcs_status_seed_pkg::DEV_VENDOR);
                        n.st = kr_pcs_status_seed_pkg::FR_TURN;
                        n.cnt = 6'h00;
                    end
                end
                kr_pcs_status_seed_pkg::FR_TURN: begin
                    if (r.op[1]) begin
                        // reads: drive the turnaround zero, then the word
                        n.st = kr_pcs_status_seed_pkg::FR_PREAMBLE;
                        n.cnt = 6'h00;
                        if (r.sel_pcs) begin
                            n.shift = pcs_word(r.addr_pcs, r, pcs_status_in);
                            n.mdio_oe = 1'b1;
                            n.mdio_o = 1'b0;
                            n.st = kr_pcs_status_seed_pkg::FR_READ;
                            clr_sub2 = (r.addr_pcs == kr_pcs_status_seed_pkg::SUBLAYER_STATUS_TWO_ADDR);
                            clr_kr2 = (r.addr_pcs == kr_pcs_status_seed_pkg::KR_STATUS_TWO_ADDR);
                            clr_err = clr_kr2;
                            if (r.op == kr_pcs_status_seed_pkg::OP_READ_INC) begin
                                n.addr_pcs = r.addr_pcs + 16'h0001;
                            end
                        end else if (r.sel_vendor) begin
                            // only the shared errored count is answered in the vendor device
                            if (r.addr_vendor == kr_pcs_status_seed_pkg::VENDOR_ERR_COUNT_ADDR) begin
                                n.shift = {8'h00, r.errored_block_count};
                                n.mdio_oe = 1'b1;
                                n.mdio_o = 1'b0;
                                n.st = kr_pcs_status_seed_pkg::FR_READ;
                                clr_err = 1'b1;
                            end
                            if (r.op == kr_pcs_status_seed_pkg::OP_READ_INC) begin
                                n.addr_vendor = r.addr_vendor + 16'h0001;
                            end
                        end
                    end else begin
                        n.cnt = r.cnt + 6'h01;
                        if (r.cnt != 6'h00) begin
                            n.st = kr_pcs_status_seed_pkg::FR_WRITE;
                            n.cnt = 6'h00;
                        end
                    end
                end
                kr_pcs_status_seed_pkg::FR_READ: begin
                    if (r.cnt == kr_pcs_status_seed_pkg::READ_EDGES) begin
                        n.mdio_oe = 1'b0;
                        n.mdio_o = 1'b0;
                        n.st = kr_pcs_status_seed_pkg::FR_PREAMBLE;
                        n.cnt = 6'h00;
                    end else begin
                        n.mdio_o = r.shift[15];
                        n.shift = {r.shift[14:0], 1'b0};
                        n.cnt = r.cnt + 6'h01;
                    end
                end
                kr_pcs_status_seed_pkg::FR_WRITE: begin
                    w = {r.shift[14:0], mdio_in};
                    n.shift = w;
                    n.cnt = r.cnt + 6'h01;
                    if (r.cnt == kr_pcs_status_seed_pkg::DATA_LAST) begin
                        n.st = kr_pcs_status_seed_pkg::FR_PREAMBLE;
                        n.cnt = 6'h00;
                        if (r.op == kr_pcs_status_seed_pkg::OP_ADDRESS) begin
                            if (r.sel_pcs) begin
                                n.addr_pcs = w;
                            end
                            if (r.sel_vendor) begin
                                n.addr_vendor = w;
                            end
                        end else if (r.op == kr_pcs_status_seed_pkg::OP_WRITE && r.sel_pcs) begin
                            if (r.addr_pcs == kr_pcs_status_seed_pkg::SEED_A_WORD0_ADDR) begin
                                n.pattern_seed_word0 = w;
                            end
                            if (r.addr_pcs == kr_pcs_status_seed_pkg::SEED_A_WORD1_ADDR) begin
                                n.pattern_seed_word1 = w;
                            end
                        end
                    end
                end
            endcase
        end

        // latches: an event in the clearing cycle survives the read
        n.transmit_fault_latch = (clr_sub2 ? 1'b0 : r.transmit_fault_latch) | pcs_status_in.transmit_fault;
        n.receive_fault_latch = (clr_sub2 ? 1'b0 : r.receive_fault_latch) | pcs_status_in.receive_fault;
        n.block_lock_latched_low = clr_kr2 ? pcs_status_in.block_lock_live
            : (r.block_lock_latched_low & pcs_status_in.block_lock_live);
        n.high_error_rate_latched = (clr_kr2 ? 1'b0 : r.high_error_rate_latched)
            | pcs_status_in.high_error_rate_live;

        if (clr_kr2) begin
            n.bad_header_entry_count = pcs_status_in.bad_sync_header_entry ? 6'h01 : 6'h00;
        end else if (pcs_status_in.bad_sync_header_entry) begin
            n.bad_header_entry_count = 6'(sat_inc({2'h0, r.bad_header_entry_count},
                {2'h0, kr_pcs_status_seed_pkg::BAD_HEADER_COUNT_MAX}));
        end
        if (clr_err) begin
            n.errored_block_count = pcs_status_in.decode_error_entry ? 8'h01 : 8'h00;
        end else if (pcs_status_in.decode_error_entry) begin
            n.errored_block_count = sat_inc(r.errored_block_count,
                kr_pcs_status_seed_pkg::ERRORED_BLOCK_COUNT_MAX);
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            r <= kr_pcs_status_seed_pkg::BANK_RESET;
        end else begin
            r <= n;
        end
    end

    assign mdio_out = r.mdio_o;
    assign mdio_oe_out = r.mdio_oe;
    assign pattern_seed_first_out = {r.pattern_seed_word1, r.pattern_seed_word0};

endmodule

// ### test/kr_pcs_status_seed_regs_chk.sv
// assertions on the mdio pins and seed output of the status register bank
// assumes mdc reaches the slave directly and is far slower than core_clk_in
`timescale 1ns/1ps
module kr_pcs_status_seed_regs_chk (
    input wire logic core_clk_in,
    input wire logic sys_rst_in,
    input wire logic kr_mode_in,
    input wire logic [4:0] port_addr_in,
    input wire logic mdc_in,
    input wire logic mdio_in,
    input wire logic mdio_out,
    input wire logic mdio_oe_out,
    input wire kr_pcs_status_seed_pkg::pcs_status_type pcs_status_in,
    input wire logic [31:0] pattern_seed_first_out
);
    logic mdc_r;
    logic [4:0] rise_cnt_r;
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (sys_rst_in);
    // the slave acts on the core edge that first sees mdc high, so effects show one cycle later
    sequence after_rise_s;
        $past(mdc_in) && !$past(mdc_in, 2);
    endsequence
    always_ff @(posedge core_clk_in) begin
        mdc_r <= mdc_in;
        if (sys_rst_in || !mdio_oe_out) rise_cnt_r <= 5'h00;
        else if (mdc_in && !mdc_r) rise_cnt_r <= rise_cnt_r + 5'h01;
    end
    chk_released_low: assert property (!mdio_oe_out |-> !mdio_out) else $error("data high while released");
    chk_mode_gate: assert property ($rose(mdio_oe_out) |-> kr_mode_in) else $error("drive outside kr mode");
    chk_turn_start: assert property ($rose(mdio_oe_out) |-> after_rise_s ##0 !mdio_out)
        else $error("turnaround drive misplaced");
    chk_read_length: assert property ($fell(mdio_oe_out) |-> rise_cnt_r == 5'h11)
        else $error("read drive length wrong");
    chk_data_timing: assert property ($changed(mdio_out) |-> after_rise_s) else $error("data moved off mdc");
    chk_oe_steady: assert property ($rose(mdio_oe_out) |=> mdio_oe_out [*8]) else $error("read drive cut");
    chk_seed_timing: assert property ($changed(pattern_seed_first_out) |-> !mdio_oe_out ##0 after_rise_s)
        else $error("seed moved outside a write");
    chk_seed_mode: assert property ($changed(pattern_seed_first_out) |-> kr_mode_in)
        else $error("seed written outside kr mode");
endmodule

// ### test/mdio_station_model.sv
// mdio management station: sends frames and samples the slave's answer
// assumes a pull-up on the mdio line, so a released line reads high
`timescale 1ns/1ps
module mdio_station_model (
    input wire logic core_clk_in,
    input wire logic mdio_out_in,
    input wire logic mdio_oe_in,
    output logic mdc_out,
    output logic mdio_line_out
);
    logic drv_en_r = 1'b0;
    logic drv_r = 1'b1;
    initial mdc_out = 1'b0;
    assign mdio_line_out = mdio_oe_in ? mdio_out_in : (drv_en_r ? drv_r : 1'b1);
    // three core cycles a phase keeps mdc slow enough; it stands still between frames
    task automatic tick(input logic en, input logic b, output logic got);
        drv_en_r <= en;
        drv_r <= b;
        mdc_out <= 1'b0;
        repeat (3) @(posedge core_clk_in);
        got = mdio_line_out;
        mdc_out <= 1'b1;
        repeat (3) @(posedge core_clk_in);
    endtask
    task automatic frame(input logic [1:0] op, input logic [4:0] port, input logic [4:0] dev,
                         input logic [15:0] wdata, output logic [15:0] rdata);
        logic [47:0] bits;
        logic got;
        bits = {32'hffff_ffff, 2'h0, op, port, dev, 2'h2};
        for (int i = 47; i >= 0; i--) tick(!(op[1] && i < 2), bits[i], got);
        for (int i = 15; i >= 0; i--) begin
            tick(!op[1], wdata[i], got);
            rdata[i] = got;
        end
        drv_en_r <= 1'b0;
        // one spare edge so a following frame never rewrites the enable in the same step
        @(posedge core_clk_in);
    endtask
endmodule

// ### test/kr_pcs_status_seed_regs_tb.sv
// self-checking bench: mdio register traffic against driven datapath status
// assumes the station model makes mdc and the pulled-up mdio line
`timescale 1ns/1ps
module kr_pcs_status_seed_regs_tb;
    localparam logic [4:0] PORT = 5'h05;
    logic core_clk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic kr_mode_in = 1'b1;
    logic [4:0] port_addr_in = PORT;
    logic mdc, line, mdio_out, mdio_oe_out;
    logic [31:0] seed, r, rng = 32'h0000_f4b3;
    logic [15:0] rd;
    kr_pcs_status_seed_pkg::pcs_status_type st = '0;
    int mismatches = 0, check_count = 0, cycles = 0;
    always #4 core_clk_in = ~core_clk_in;
    kr_pcs_status_seed_regs kr_pcs_status_seed_regs_inst (.core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in),
        .kr_mode_in(kr_mode_in), .port_addr_in(port_addr_in), .mdc_in(mdc), .mdio_in(line),
        .mdio_out(mdio_out), .mdio_oe_out(mdio_oe_out), .pcs_status_in(st), .pattern_seed_first_out(seed));
    mdio_station_model mdio_station_model_inst (.core_clk_in(core_clk_in), .mdio_out_in(mdio_out),
        .mdio_oe_in(mdio_oe_out), .mdc_out(mdc), .mdio_line_out(line));
    function automatic logic [31:0] xs();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng;
    endfunction
    // second kr status word from the event counts, with the counters saturating
    function automatic logic [15:0] kr_two_exp(input logic ll, input logic lh, input int nb, input int ne);
        logic [5:0] b;
        logic [7:0] e;
        b = (nb > 63) ? kr_pcs_status_seed_pkg::BAD_HEADER_COUNT_MAX : 6'(nb);
        e = (ne > 255) ? kr_pcs_status_seed_pkg::ERRORED_BLOCK_COUNT_MAX : 8'(ne);
        kr_two_exp = {ll, lh, b, e};
    endfunction
    task automatic final_report();
        if (mismatches == 0 && check_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
            mismatches++;
        end
    endtask
    // on reads v is the expected word
    task automatic acc(input logic [1:0] op, input logic [4:0] dev, input logic [15:0] a, input logic [15:0] v);
        logic [15:0] d;
        mdio_station_model_inst.frame(2'h0, PORT, dev, a, d);
        mdio_station_model_inst.frame(op, PORT, dev, v, d);
        if (op[1]) check(d, v);
    endtask
    task automatic pulse(input logic [8:0] nb, input logic [8:0] ne, input logic blip);
        for (int i = 0; i < 300; i++) begin
            st.bad_sync_header_entry <= i < nb;
            st.decode_error_entry <= i < ne;
            st.block_lock_live <= !(blip && i == 0);
            st.high_error_rate_live <= blip && i == 0;
            @(posedge core_clk_in);
            st.bad_sync_header_entry <= 1'b0;
            st.decode_error_entry <= 1'b0;
            @(posedge core_clk_in);
        end
    endtask
    // about 23400 cycles of traffic are expected
    always @(posedge core_clk_in) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            mismatches++;
            final_report();
        end
    end
    initial begin
        repeat (6) @(posedge core_clk_in);
        sys_rst_in <= 1'b0;
        @(posedge core_clk_in);
        acc(2'h3, 5'h03, 16'h0008, 16'h8001);
        acc(2'h3, 5'h03, 16'h0020, 16'h0004);
        acc(2'h3, 5'h03, 16'h0021, 16'h0000);
        acc(2'h3, 5'h03, 16'h0023, 16'h0000);
        acc(2'h3, 5'h03, 16'h0030, 16'h0000);
        r = xs();
        acc(2'h1, 5'h03, 16'h0022, r[15:0]);
        acc(2'h1, 5'h03, 16'h0023, r[31:16]);
        check(seed[31:16], r[31:16]);
        check(seed[15:0], r[15:0]);
        kr_mode_in <= 1'b0;
        acc(2'h1, 5'h03, 16'h0022, ~r[15:0]);
        acc(2'h3, 5'h03, 16'h0022, 16'hffff);
        kr_mode_in <= 1'b1;
        port_addr_in <= PORT ^ 5'h01;
        acc(2'h3, 5'h03, 16'h0008, 16'hffff);
        port_addr_in <= PORT;
        acc(2'h3, 5'h03, 16'h0022, r[15:0]);
        mdio_station_model_inst.frame(2'h2, PORT, 5'h03, 16'h0000, rd);
        check(rd, r[15:0]);
        mdio_station_model_inst.frame(2'h3, PORT, 5'h03, 16'h0000, rd);
        check(rd, r[31:16]);
        for (int i = 0; i < 8; i++) begin
            st.receive_link_up <= i[2];
            st.high_error_rate_live <= i[1];
            st.block_lock_live <= i[0];
            @(posedge core_clk_in);
            acc(2'h3, 5'h03, 16'h0020, {3'h0, i[2], 9'h000, 1'b1, i[1], i[0]});
        end
        st.transmit_fault <= 1'b1;
        st.receive_fault <= 1'b1;
        st.high_error_rate_live <= 1'b0;
        @(posedge core_clk_in);
        st.transmit_fault <= 1'b0;
        st.receive_fault <= 1'b0;
        acc(2'h3, 5'h03, 16'h0008, 16'h8c01);
        acc(2'h3, 5'h03, 16'h0008, 16'h8001);
        acc(2'h3, 5'h03, 16'h0021, 16'h4000);
        pulse(9'h046, 9'h12c, 1'b1);
        acc(2'h3, 5'h03, 16'h0021, 16'h7fff);
        r = xs();
        pulse({2'h0, r[6:0]}, {1'h0, r[15:8]}, 1'b0);
        acc(2'h3, 5'h03, 16'h0021, kr_two_exp(1'b1, 1'b0, r[6:0], r[15:8]));
        pulse(9'h000, 9'h005, 1'b0);
        acc(2'h3, 5'h1e, 16'h0010, 16'h0005);
        acc(2'h3, 5'h03, 16'h0021, 16'h8000);
        sys_rst_in <= 1'b1;
        repeat (2) @(posedge core_clk_in);
        sys_rst_in <= 1'b0;
        @(posedge core_clk_in);
        check(seed[15:0], 16'h0000);
        check(seed[31:16], 16'h0000);
        acc(2'h3, 5'h03, 16'h0021, 16'h0000);
        final_report();
    end
endmodule
bind kr_pcs_status_seed_regs kr_pcs_status_seed_regs_chk kr_pcs_status_seed_regs_chk_inst (
    .core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in), .kr_mode_in(kr_mode_in), .port_addr_in(port_addr_in),
    .mdc_in(mdc_in), .mdio_in(mdio_in), .mdio_out(mdio_out), .mdio_oe_out(mdio_oe_out),
    .pcs_status_in(pcs_status_in), .pattern_seed_first_out(pattern_seed_first_out));
